// ===== hdl/bpc_port.sv
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "bpc_defs.svh"

module bpc_port (
	input  wire logic        CLK_SYS,
	input  wire logic        RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [13:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [7:0]  PIN_IN,
	output logic      [7:0]  PIN_OUT,
	output logic      [7:0]  PIN_OE,
	output logic      [7:0]  PULLUP_EN,
	output logic             IRQ,
	output logic             WAKE
);

	bpc_pkg::bpc_state_s st;
	bpc_pkg::bpc_state_s next_st;

	logic       acc;         // access phase of a transfer
	logic       setup;       // setup phase: read data is fetched here
	logic       wr;
	logic       rd;
	logic       rd_setup;
	logic       hit;
	logic       port_hit;
	logic [3:0] mismatch;
	logic       ext_edge;
	logic       ext_lvl;
	logic       ext_live;
	logic [7:0] rd_value;

	////////////////////////////////////////////////////////////////////////////////////
	// bus decode: no wait states; a read is fetched in the setup cycle so that
	// the registered read data already stands when the access edge samples it
	assign acc      = PSEL & PENABLE;
	assign setup    = PSEL & ~PENABLE;
	assign wr       = acc & PWRITE;
	assign rd       = acc & ~PWRITE;
	assign rd_setup = setup & ~PWRITE;
	assign port_hit = (PADDR == `BPC_ADDR_PORT_DATA);
	assign PREADY   = 1'b1;
	assign PSLVERR  = acc & ~hit;
	assign PRDATA   = {24'h000000, st.rdata};

	// read multiplexer; unmapped words read as zero
	always_comb begin
		unique case (PADDR)
			`BPC_ADDR_PORT_DATA:   rd_value = st.pin_s2;
			`BPC_ADDR_IRQ_CONTROL: rd_value = st.ctl;
			`BPC_ADDR_OPTIONS:     rd_value = st.opt;
			`BPC_ADDR_DIRECTION:   rd_value = st.dir;
			`BPC_ADDR_IRQ_STATUS:  rd_value = {6'h00, st.evt};
			`BPC_ADDR_IRQ_MASK:    rd_value = {6'h00, st.mask};
			default:               rd_value = 8'h00;
		endcase
	end

	// address decode of the six mapped words
	always_comb begin
		unique case (PADDR)
			`BPC_ADDR_PORT_DATA, `BPC_ADDR_IRQ_CONTROL, `BPC_ADDR_OPTIONS,
			`BPC_ADDR_DIRECTION, `BPC_ADDR_IRQ_STATUS, `BPC_ADDR_IRQ_MASK: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////////
	// pin drivers and pull-ups
	assign PIN_OUT   = st.latch;
	assign PIN_OE    = ~st.dir;
	assign PULLUP_EN = st.dir & {8{~st.opt[`BPC_OPT_PULLUP_N]}};

	// change comparison on input sense pins only
	assign mismatch = (st.pin_s2[7:4] ^ st.snap) & st.dir[7:4];

	// external edge detector on synchronised pin 0; it stays quiet until the
	// synchroniser and the previous-level flop hold real levels after reset
	assign ext_lvl  = st.pin_s2[0];
	assign ext_live = (st.warm == 2'h3);
	assign ext_edge = ext_live & (st.opt[`BPC_OPT_EDGE_SEL] ? (ext_lvl & ~st.ext_prev)
	                                                       : (~ext_lvl & st.ext_prev));

	// level interrupt and wake request
	assign IRQ  = |(st.evt & st.mask);
	assign WAKE = st.ctl[`BPC_CTL_CHANGE_FLAG] & st.ctl[`BPC_CTL_CHANGE_EN];

	////////////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		next_st        = st;
		next_st.pin_s1 = PIN_IN;
		next_st.pin_s2 = st.pin_s1;
		next_st.ext_prev = ext_lvl;
		next_st.warm     = ext_live ? st.warm : st.warm + 2'h1;
		// register writes
		if (wr) begin
			unique case (PADDR)
				`BPC_ADDR_PORT_DATA:   next_st.latch = PWDATA[7:0];
				`BPC_ADDR_IRQ_CONTROL: next_st.ctl   = PWDATA[7:0];
				`BPC_ADDR_OPTIONS:     next_st.opt   = PWDATA[7:0];
				`BPC_ADDR_DIRECTION:   next_st.dir   = PWDATA[7:0];
				`BPC_ADDR_IRQ_STATUS:  next_st.evt   = st.evt & ~PWDATA[1:0];
				`BPC_ADDR_IRQ_MASK:    next_st.mask  = PWDATA[1:0];
				default: ;
			endcase
		end
		// read data is fetched in the setup cycle and stands through the access
		if (rd_setup)
			next_st.rdata = rd_value;
		// port access refreshes the snapshot
		if (acc && port_hit)
			next_st.snap = st.pin_s2[7:4];
		// hardware sets win over software clears
		if (|mismatch) begin
			next_st.ctl[`BPC_CTL_CHANGE_FLAG] = 1'b1;
			next_st.evt[`BPC_EVT_CHANGE]      = 1'b1;
		end
		if (ext_edge) begin
			next_st.ctl[`BPC_CTL_EXT_FLAG] = 1'b1;
			next_st.evt[`BPC_EVT_EXT]      = 1'b1;
		end
	end

	// state register
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			st          <= '0;
			st.latch    <= `BPC_RST_LATCH;
			st.dir      <= `BPC_RST_DIRECTION;
			st.opt      <= `BPC_RST_OPTIONS;
			st.ctl      <= `BPC_RST_CONTROL;
			st.mask     <= `BPC_RST_MASK;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// assertions
	sequence s_port_access;
		PSEL && PENABLE && PADDR == `BPC_ADDR_PORT_DATA;
	endsequence

	property p_dir_in;
		@(posedge CLK_SYS) disable iff (RST) PIN_OE == ~st.dir;
	endproperty
	a_dir_in: assert property (p_dir_in) else $error("output enable not inverse of direction");

	property p_drive;
		@(posedge CLK_SYS) disable iff (RST)
			(wr && PADDR == `BPC_ADDR_PORT_DATA) |=> PIN_OUT == $past(PWDATA[7:0]);
	endproperty
	a_drive: assert property (p_drive) else $error("latch not loaded by port write");

	property p_pullup;
		@(posedge CLK_SYS) disable iff (RST)
			(PULLUP_EN & ~st.dir) == 8'h00 && (st.opt[7] -> PULLUP_EN == 8'h00);
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up on where it must be off");

	property p_pu_reset;
		@(posedge CLK_SYS) $fell(RST) |-> PULLUP_EN == 8'h00 && st.dir == 8'hFF;
	endproperty
	a_pu_reset: assert property (p_pu_reset) else $error("reset state wrong");

	property p_out_excluded;
		@(posedge CLK_SYS) disable iff (RST) (st.dir[7:4] == 4'h0) |-> mismatch == 4'h0;
	endproperty
	a_out_excluded: assert property (p_out_excluded) else $error("output pin in compare");

	property p_flag_set;
		@(posedge CLK_SYS) disable iff (RST) (|mismatch) |=> st.ctl[0] && st.evt[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("mismatch did not set flag");

	property p_snap;
		@(posedge CLK_SYS) disable iff (RST) s_port_access |=> st.snap == $past(st.pin_s2[7:4]);
	endproperty
	a_snap: assert property (p_snap) else $error("snapshot not refreshed");

	property p_sticky;
		@(posedge CLK_SYS) disable iff (RST)
			(st.ctl[0] && !(wr && PADDR == `BPC_ADDR_IRQ_CONTROL)) |=> st.ctl[0];
	endproperty
	a_sticky: assert property (p_sticky) else $error("change flag dropped");

	property p_ext;
		@(posedge CLK_SYS) disable iff (RST) ext_edge |=> st.evt[1] && (IRQ || !st.mask[1]);
	endproperty
	a_ext: assert property (p_ext) else $error("edge event lost");

	// further bus phases shared by the checks below
	sequence s_port_write;
		PSEL && PENABLE && PWRITE && PADDR == `BPC_ADDR_PORT_DATA;
	endsequence

	sequence s_ctl_write;
		PSEL && PENABLE && PWRITE && PADDR == `BPC_ADDR_IRQ_CONTROL;
	endsequence

	sequence s_status_clear;
		PSEL && PENABLE && PWRITE && PADDR == `BPC_ADDR_IRQ_STATUS && PWDATA[0];
	endsequence

	sequence s_access_then_quiet;
		s_port_access ##1 $stable(st.pin_s2[7:4]);
	endsequence

	// latch only moves on a port write
	property p_latch_hold;
		@(posedge CLK_SYS) disable iff (RST)
			!(PSEL && PENABLE && PWRITE && port_hit) |=> $stable(PIN_OUT);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch moved without write");

	// cleared enable bit gives every input its pull-up
	property p_pullup_on;
		@(posedge CLK_SYS) disable iff (RST)
			!st.opt[`BPC_OPT_PULLUP_N] |-> PULLUP_EN == st.dir;
	endproperty
	a_pullup_on: assert property (p_pullup_on) else $error("pull-up missing on input");

	// the change flag only rises from an upper input pin or a software write
	property p_upper_only;
		@(posedge CLK_SYS) disable iff (RST)
			$rose(st.ctl[0]) |-> $past(|((st.pin_s2[7:4] ^ st.snap) & st.dir[7:4]))
				|| $past(wr && PADDR == `BPC_ADDR_IRQ_CONTROL && PWDATA[0]);
	endproperty
	a_upper_only: assert property (p_upper_only) else $error("flag from wrong pin");

	// snapshot is kept between port accesses
	property p_snap_hold;
		@(posedge CLK_SYS) disable iff (RST)
			!(acc && port_hit) |=> $stable(st.snap);
	endproperty
	a_snap_hold: assert property (p_snap_hold) else $error("snapshot moved");

	// change event only comes from a mismatch
	property p_evt_rise;
		@(posedge CLK_SYS) disable iff (RST)
			$rose(st.evt[0]) |-> $past(|mismatch);
	endproperty
	a_evt_rise: assert property (p_evt_rise) else $error("change event without mismatch");

	// unmasked change event raises the line
	property p_irq_change;
		@(posedge CLK_SYS) disable iff (RST)
			(st.evt[0] && st.mask[0]) |-> IRQ;
	endproperty
	a_irq_change: assert property (p_irq_change) else $error("change irq missing");

	// no event, no interrupt
	property p_irq_quiet;
		@(posedge CLK_SYS) disable iff (RST)
			(st.evt == 2'h0) |-> !IRQ;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq with no event");

	// enabled change flag wakes the core
	property p_wake;
		@(posedge CLK_SYS) disable iff (RST)
			(st.ctl[0] && st.ctl[3]) |-> WAKE;
	endproperty
	a_wake: assert property (p_wake) else $error("wake missing");

	// an access with quiet pins ends the mismatch
	property p_access_ends;
		@(posedge CLK_SYS) disable iff (RST)
			s_access_then_quiet |-> mismatch == 4'h0;
	endproperty
	a_access_ends: assert property (p_access_ends) else $error("mismatch survived access");

	// a lasting mismatch beats a control write
	property p_persist;
		@(posedge CLK_SYS) disable iff (RST)
			s_ctl_write ##0 (mismatch != 4'h0) |=> st.ctl[0];
	endproperty
	a_persist: assert property (p_persist) else $error("flag cleared during mismatch");

	// with the mismatch gone a clear takes effect
	property p_clear_after;
		@(posedge CLK_SYS) disable iff (RST)
			s_status_clear ##0 (mismatch == 4'h0) |=> !st.evt[0];
	endproperty
	a_clear_after: assert property (p_clear_after) else $error("clear had no effect");

	// rising edge selected
	property p_ext_rise;
		@(posedge CLK_SYS) disable iff (RST)
			(ext_live && st.opt[6] && $rose(st.pin_s2[0])) |=> st.evt[1];
	endproperty
	a_ext_rise: assert property (p_ext_rise) else $error("rising edge missed");

	// falling edge selected
	property p_ext_fall;
		@(posedge CLK_SYS) disable iff (RST)
			(ext_live && !st.opt[6] && $fell(st.pin_s2[0])) |=> st.evt[1];
	endproperty
	a_ext_fall: assert property (p_ext_fall) else $error("falling edge missed");

	// edge event only comes from a detected edge
	property p_ext_source;
		@(posedge CLK_SYS) disable iff (RST)
			$rose(st.evt[1]) |-> $past(ext_edge);
	endproperty
	a_ext_source: assert property (p_ext_source) else $error("edge event from nowhere");

	// no false edge while the synchroniser fills after reset
	property p_no_false_edge;
		@(posedge CLK_SYS)
			$fell(RST) |-> !ext_edge ##1 !ext_edge ##1 !ext_edge;
	endproperty
	a_no_false_edge: assert property (p_no_false_edge) else $error("false edge after reset");

	// masked edge event keeps the line low
	property p_ext_masked;
		@(posedge CLK_SYS) disable iff (RST)
			(st.evt[1] && !st.mask[1] && !(st.evt[0] && st.mask[0])) |-> !IRQ;
	endproperty
	a_ext_masked: assert property (p_ext_masked) else $error("masked edge raised irq");

	// every pin starts as an input
	property p_dir_reset;
		@(posedge CLK_SYS)
			$fell(RST) |-> st.dir == 8'hFF && PIN_OE == 8'h00;
	endproperty
	a_dir_reset: assert property (p_dir_reset) else $error("direction reset wrong");

	// port read returns the pin levels
	property p_read_pins;
		@(posedge CLK_SYS) disable iff (RST)
			(rd && port_hit) |-> PRDATA[7:0] == $past(st.pin_s2);
	endproperty
	a_read_pins: assert property (p_read_pins) else $error("port read not pin levels");

	// port write leaves direction and options alone
	property p_write_latch;
		@(posedge CLK_SYS) disable iff (RST)
			s_port_write |=> $stable(st.dir) && $stable(st.opt);
	endproperty
	a_write_latch: assert property (p_write_latch) else $error("port write leaked");

	// status copy of the change flag is sticky too
	property p_status_sticky;
		@(posedge CLK_SYS) disable iff (RST)
			(st.evt[0] && !(wr && PADDR == `BPC_ADDR_IRQ_STATUS)) |=> st.evt[0];
	endproperty
	a_status_sticky: assert property (p_status_sticky) else $error("status flag dropped");

endmodule : bpc_port

// ===== hdl/bpc_defs.svh
`ifndef BPC_DEFS_SVH
`define BPC_DEFS_SVH

// register byte addresses (printed offsets are not all multiples of four: index times four)
`define BPC_IDX_PORT_DATA     12'h106
`define BPC_IDX_IRQ_CONTROL   12'h10B
`define BPC_IDX_OPTIONS       12'h181
`define BPC_IDX_DIRECTION     12'h186
`define BPC_IDX_IRQ_STATUS    12'h190
`define BPC_IDX_IRQ_MASK      12'h191
`define BPC_ADDR_PORT_DATA    14'h0418
`define BPC_ADDR_IRQ_CONTROL  14'h042C
`define BPC_ADDR_OPTIONS      14'h0604
`define BPC_ADDR_DIRECTION    14'h0618
`define BPC_ADDR_IRQ_STATUS   14'h0640
`define BPC_ADDR_IRQ_MASK     14'h0644

// field positions
`define BPC_OPT_PULLUP_N      7
`define BPC_OPT_EDGE_SEL      6
`define BPC_CTL_CHANGE_FLAG   0
`define BPC_CTL_EXT_FLAG      1
`define BPC_CTL_CHANGE_EN     3
`define BPC_CTL_EXT_EN        4
`define BPC_EVT_CHANGE        0
`define BPC_EVT_EXT           1

// reset values
`define BPC_RST_OPTIONS       8'hFF
`define BPC_RST_DIRECTION     8'hFF
`define BPC_RST_LATCH         8'h00
`define BPC_RST_CONTROL       8'h00
`define BPC_RST_MASK          2'h0

`endif

// ===== hdl/bpc_pkg.sv
package bpc_pkg;

	// packed state of the port block
	typedef struct packed {
		logic [7:0] latch;
		logic [7:0] dir;
		logic [7:0] opt;
		logic [7:0] ctl;
		logic [1:0] evt;
		logic [1:0] mask;
		logic [3:0] snap;
		logic [7:0] pin_s1;
		logic [7:0] pin_s2;
		logic       ext_prev;
		logic [1:0] warm;        // counts edges after reset until pin 0 history is real
		logic [7:0] rdata;
	} bpc_state_s;

endpackage : bpc_pkg

// ===== tb/bpc_pins_model.sv
`timescale 1ns/1ps

// keypad side: each line driven, released, or left open
module bpc_pins_model (
	input  wire logic       clk,
	input  wire logic [7:0] drv,
	input  wire logic [7:0] drv_en,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pull_en,
	output logic      [7:0] level
);
	logic flip = 1'b0;

	// an open line with no pull-up wanders every cycle
	always @(posedge clk) flip <= ~flip;

	// wire level from every party's enable
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			level[i] = pin_oe[i] ? pin_out[i] : drv_en[i] ? drv[i] : pull_en[i] ? 1'b1 : flip;
		end
	end
endmodule : bpc_pins_model

// ===== tb/bidir_port_with_change_irq_tb.sv
`timescale 1ns/1ps
`include "bpc_defs.svh"

module bidir_port_with_change_irq_tb;
	logic        CLK_SYS = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [13:0] PADDR = '0;
	logic [31:0] PWDATA = '0, PRDATA;
	logic        PREADY, PSLVERR, IRQ, WAKE;
	logic [7:0]  PIN_IN, PIN_OUT, PIN_OE, PULLUP_EN, drv = 0, drv_en = 8'hFF;
	logic [3:0]  lo;
	logic [31:0] q[$];
	int          errors = 0, n_checks = 0;
	integer      seed = 32'hA41D04E0;

	bpc_port i_dut (.CLK_SYS, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
		.PREADY, .PSLVERR, .PIN_IN, .PIN_OUT, .PIN_OE, .PULLUP_EN, .IRQ, .WAKE);
	bpc_pins_model i_pins (.clk(CLK_SYS), .drv(drv), .drv_en(drv_en), .pin_out(PIN_OUT),
		.pin_oe(PIN_OE), .pull_en(PULLUP_EN), .level(PIN_IN));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one apb transfer; read data is taken at the access edge by the watcher
	task automatic xfer(input logic wr, input logic [13:0] a, input logic [31:0] d);
		@(posedge CLK_SYS);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		do @(posedge CLK_SYS); while (PREADY !== 1'b1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK_SYS);
	endtask : xfer

	task automatic rd(input logic [13:0] a, input logic [31:0] exp);
		q.push_back(exp);
		xfer(1'b0, a, 32'h0);
	endtask : rd

	// clear both copies of the flags
	task automatic clr;
		xfer(1'b1, `BPC_ADDR_IRQ_STATUS, 32'h3);
		xfer(1'b1, `BPC_ADDR_IRQ_CONTROL, 32'h8);
	endtask : clr

	// move one keypad line and let it pass the synchroniser
	task automatic pin(input int i, input logic v);
		@(posedge CLK_SYS);
		drv[i] <= v;
		repeat (5) @(posedge CLK_SYS);
		@(negedge CLK_SYS);
	endtask : pin

	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////////////////////
	// clock and watchers: read data against the oldest note, refusal flag
	initial forever #12.5 CLK_SYS = ~CLK_SYS;
	always @(posedge CLK_SYS)
		if (PSEL && PENABLE && PREADY && !PWRITE) chk("read", PRDATA, q.pop_front());
	always @(posedge CLK_SYS) if (PSEL && PENABLE && PADDR == 14'h0) chk("err", PSLVERR, 1);

	// watchdog
	initial begin
		repeat (20000) @(posedge CLK_SYS);
		errors++;
		final_report();
	end

	// main sequence; the port is only read where a snapshot is wanted
	initial begin
		repeat (16) @(posedge CLK_SYS);
		RST <= 1'b0;
		rd(`BPC_ADDR_DIRECTION, 32'hFF);
		rd(`BPC_ADDR_OPTIONS, 32'hFF);
		@(negedge CLK_SYS);
		chk("pull", PULLUP_EN, 32'h0);
		chk("oe", PIN_OE, 32'h0);
		lo = 4'($random(seed));
		drv[3:0] <= lo;
		xfer(1'b1, `BPC_ADDR_DIRECTION, 32'h0F);
		xfer(1'b1, `BPC_ADDR_PORT_DATA, 32'hA5);
		rd(`BPC_ADDR_PORT_DATA, {24'h0, 4'hA, lo});
		xfer(1'b1, `BPC_ADDR_OPTIONS, 32'h7F);
		drv_en <= 8'h00;
		repeat (4) @(posedge CLK_SYS);
		chk("pull", PULLUP_EN, 32'h0F);
		rd(`BPC_ADDR_PORT_DATA, 32'hAF);
		drv_en <= 8'hFF;
		drv <= 8'h00;
		xfer(1'b1, `BPC_ADDR_DIRECTION, 32'hFF);
		xfer(1'b1, `BPC_ADDR_OPTIONS, 32'hFF);
		xfer(1'b1, `BPC_ADDR_IRQ_MASK, 32'h3);
		rd(`BPC_ADDR_PORT_DATA, 32'h0);
		clr();
		pin(2, 1'b1);
		chk("irq", IRQ, 32'h0);
		pin(5, 1'b1);
		chk("irq", IRQ, 32'h1);
		chk("wake", WAKE, 32'h1);
		clr();
		@(negedge CLK_SYS);
		chk("irq", IRQ, 32'h1);
		pin(5, 1'b0);
		chk("irq", IRQ, 32'h1);
		pin(5, 1'b1);
		xfer(1'b1, `BPC_ADDR_PORT_DATA, 32'h0);
		clr();
		@(negedge CLK_SYS);
		chk("irq", IRQ, 32'h0);
		pin(7, 1'b1);
		rd(`BPC_ADDR_PORT_DATA, 32'hA4);
		clr();
		xfer(1'b1, `BPC_ADDR_DIRECTION, 32'h7F);
		pin(7, 1'b1);
		chk("irq", IRQ, 32'h0);
		xfer(1'b1, `BPC_ADDR_IRQ_MASK, 32'h2);
		// rising edge selected, then falling
		for (int e = 0; e < 2; e++) begin
			xfer(1'b1, `BPC_ADDR_OPTIONS, e ? 32'hBF : 32'hFF);
			clr();
			pin(0, e ? 1'b0 : 1'b1);
			chk("ext", IRQ, 32'h1);
		end
		rd(14'h0000, 32'h0);
		final_report();
	end
endmodule : bidir_port_with_change_irq_tb
